// file: design/bsm_boot_strap_select.sv
// Purpose: Capture boot strap levels and choose the boot flow
// Assumes: Strap and receive inputs synchronous to clk_in
// Notes: Outputs settle once done_out rises
//        Strap and rx motion after the decision is ignored
//
// Functional notes
// RULE1 - Sample three strap pins at power-up
// RULE2 - Hold code in register before release
// RULE3 - Code 100 waits forever for serial load
// RULE4 - Host must change straps to leave loading
// RULE5 - Code 001 gives two-wire debug only
// RULE6 - Code 000 gives four-wire debug run
// RULE7 - Code 010 checks break, load or run
// RULE8 - Code 011 starts factory image restore
// RULE9 - Board pulls straps down, suggested values
// RULE10 - Strap bit two reused as output only
// RULE11 - Strap bits zero, one never general use
// RULE12 - Pull-up is one; unknown codes four-wire
`timescale 1ns/10ps
`default_nettype none
module bsm_boot_strap_select
  import bsm_pkg::*;
(
  input wire logic clk_in, // 250 MHz clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic clk_en_in, // Freezes all state when low
  input wire logic [bsm_pkg::STRAP_W-1:0] boot_strap_in, // Strap pin levels
  input wire logic serial_rx_in, // First serial port receive line
  output logic done_out, // Boot decision made
  output logic [bsm_pkg::STRAP_W-1:0] strap_code_out, // Held strap code
  output var bsm_pkg::bsm_flow_t flow_out, // Selected boot flow
  output logic serial_load_out, // Wait for serial code load
  output logic functional_out, // Run functional image
  output logic factory_restore_out, // Start factory restore
  output logic four_wire_debug_out, // Debug pins in four-wire mapping
  output logic two_wire_debug_out, // Debug pins in two-wire mapping
  output logic strap2_reusable_out, // Bit 2 pin free for output use
  output logic strap01_general_out // Bits 0/1 offered as general pins
);
  import bsm_pkg::*;

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  bsm_state_t state_q, state_d;
  logic [SETTLE_W-1:0] settle_q, settle_d;
  logic [STRAP_W-1:0] code_q;
  bsm_flow_t flow_q;
  logic load_q, run_q, restore_q, four_q;
  bsm_flow_t dec_flow;
  logic dec_four;

  // Settle window gives the board pulls time to charge the strap pins;
  // a heavily loaded strap with a weak pull may need a longer window
  wire settle_end = (settle_q == SETTLE_LAST);
  wire capture = (state_q == BSM_ST_SETTLE) && settle_end && clk_en_in;
  wire decide = (state_q == BSM_ST_DECIDE) && clk_en_in;
  // Idle line reads high; low at decision is a break.
  // Single sample: a break that ends before the decide edge is missed,
  // traded for a detector with no timer of its own
  wire rx_break = !serial_rx_in;

  always_comb
  begin
    state_d = state_q;
    settle_d = settle_q;
    case (state_q)
      BSM_ST_SETTLE:
      begin
        settle_d = settle_q + 3'h1;
        if (settle_end)
        begin
          state_d = BSM_ST_DECIDE;
        end
      end
      BSM_ST_DECIDE: state_d = BSM_ST_DONE;
      BSM_ST_DONE: state_d = BSM_ST_DONE; // Only a new reset samples again
      default: state_d = BSM_ST_SETTLE;
    endcase
  end

  // Clock enable low holds the count, so a stalled boot decides late, never early
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= BSM_ST_SETTLE;
      settle_q <= SETTLE_ZERO;
    end
    else if (clk_en_in)
    begin
      state_q <= state_d;
      settle_q <= settle_d;
    end
  end

  // Straps caught once after release, never from reset itself
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      code_q <= STRAP_RST;
    end
    else if (capture)
    begin
      code_q <= boot_strap_in; // see RULE1, RULE2, RULE12
    end
  end

  bsm_decode u_decode
  (
    .code_in(code_q),
    .flow_out(dec_flow),
    .four_wire_out(dec_four)
  );

  // ----------------------------------------
  // Flow decision
  // ----------------------------------------
  wire dec_load = (dec_flow == BSM_SERIAL_LOAD_BOOT) ||
                  ((dec_flow == BSM_BREAK_DETECT_BOOT) && rx_break); // see RULE3, RULE7
  wire dec_restore = (dec_flow == BSM_FACTORY_RESTORE_BOOT); // see RULE8
  wire dec_run = !dec_load && !dec_restore;

  // Decision registers load once; later strap or rx motion is ignored

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      flow_q <= BSM_RUN_WITH_FOUR_WIRE_DEBUG;
      load_q <= 1'b0;
      run_q <= 1'b0;
      restore_q <= 1'b0;
      four_q <= 1'b1;
    end
    else if (decide)
    begin
      flow_q <= dec_flow; // see RULE2
      load_q <= dec_load; // No timeout: held until next reset, see RULE3, RULE4
      run_q <= dec_run;
      restore_q <= dec_restore;
      four_q <= dec_four; // see RULE5, RULE6
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign done_out = (state_q == BSM_ST_DONE);
  assign strap_code_out = code_q;
  assign flow_out = flow_q;
  assign serial_load_out = load_q;
  assign functional_out = run_q;
  assign factory_restore_out = restore_q;
  assign four_wire_debug_out = four_q;
  assign two_wire_debug_out = !four_q;
  assign strap2_reusable_out = done_out; // see RULE10
  assign strap01_general_out = 1'b0; // Shared with analog test, see RULE11

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Checks sleep through reset; reset values are judged by the bench

  chk_code_held: assert property (done_out && clk_en_in |=> $stable(code_q)) // see RULE2
    else $error("strap code changed after decision");
  chk_load_code: assert property ($rose(done_out) && code_q == SERIAL_LOAD_CODE |-> serial_load_out) // see RULE3
    else $error("load code did not select serial load");
  chk_load_forever: assert property (done_out && serial_load_out |=> serial_load_out) // see RULE3
    else $error("serial load left without reset");
  chk_two_wire: assert property ($rose(done_out) && code_q == TWO_WIRE_RUN_CODE // see RULE5
    |-> two_wire_debug_out && functional_out)
    else $error("two-wire code mapped wrong");
  chk_four_run: assert property ($rose(done_out) && code_q == FOUR_WIRE_RUN_CODE // see RULE6
    |-> four_wire_debug_out && functional_out)
    else $error("four-wire code mapped wrong");
  chk_break_pick: assert property (decide && code_q == BREAK_DETECT_CODE // see RULE7
    |=> serial_load_out == $past(rx_break) && functional_out != $past(rx_break) && four_wire_debug_out)
    else $error("break detect outcome wrong");
  chk_restore_pick: assert property ($rose(done_out) |-> factory_restore_out == (code_q == FACTORY_RESTORE_CODE)) // see RULE8
    else $error("factory restore decision wrong");
  chk_one_flow: assert property (done_out |-> $onehot({serial_load_out, functional_out, factory_restore_out})) // see RULE1
    else $error("not exactly one boot flow");
  chk_unknown_code: assert property ($rose(done_out) && code_q[2] && code_q[1:0] != 2'b00 // see RULE12
    |-> functional_out && four_wire_debug_out)
    else $error("unassigned code not four-wire run");
  chk_general_off: assert property (!strap01_general_out) // see RULE11
    else $error("bits 0 and 1 offered as general pins");
  chk_load_four: assert property (done_out && serial_load_out |-> four_wire_debug_out) // see RULE3
    else $error("serial load without four-wire debug");

  // Capture and hold: the code moves only at the one capture edge
  chk_capture_edge: assert property (capture |=> code_q == $past(boot_strap_in)) // see RULE1
    else $error("strap code not taken at capture");
  chk_capture_once: assert property (!capture |=> $stable(code_q)) // see RULE2
    else $error("strap code moved outside capture");
  chk_settle_bound: assert property (state_q == BSM_ST_SETTLE |-> settle_q <= SETTLE_LAST) // see RULE1
    else $error("settle count past its last value");

  // No flow may show before the decision, and none may move after it
  chk_no_early_flow: assert property (!done_out // see RULE2
    |-> !serial_load_out && !functional_out && !factory_restore_out)
    else $error("boot flow shown before decision");
  chk_flow_held: assert property (done_out // see RULE2
    |=> $stable(flow_q) && $stable(functional_out) && $stable(factory_restore_out) && $stable(four_q))
    else $error("boot flow moved after decision");
  chk_done_follows: assert property (decide |=> done_out) // see RULE2
    else $error("decision did not raise done");
  chk_enable_freeze: assert property (!clk_en_in // see RULE1
    |=> $stable(state_q) && $stable(settle_q) && $stable(code_q) && $stable(flow_q))
    else $error("state moved with clock enable low");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  // Reach of the scenarios: each flow and both debug mappings
  cov_load: cover property ($rose(done_out) && serial_load_out);
  cov_break_run: cover property ($rose(done_out) && flow_q == BSM_BREAK_DETECT_BOOT && functional_out);
  cov_restore: cover property ($rose(done_out) && factory_restore_out);
  cov_two_wire: cover property ($rose(done_out) && two_wire_debug_out);
  cov_four_run: cover property ($rose(done_out) && flow_q == BSM_RUN_WITH_FOUR_WIRE_DEBUG && functional_out);
endmodule // bsm_boot_strap_select
`default_nettype wire

// file: design/bsm_decode.sv
// Purpose: Decode a held strap code into a flow and debug width
// Assumes: Code already held in a register
// Notes: Pure combinational
`timescale 1ns/10ps
`default_nettype none
module bsm_decode
  import bsm_pkg::*;
(
  input wire logic [bsm_pkg::STRAP_W-1:0] code_in, // Held strap code
  output var bsm_pkg::bsm_flow_t flow_out, // Selected boot flow
  output logic four_wire_out // Four-wire debug mapping
);
  import bsm_pkg::*;

  // Unassigned codes fall back to four-wire run
  function automatic bsm_flow_t bsm_flow_of(input logic [2:0] c);
    case (c)
      SERIAL_LOAD_CODE: bsm_flow_of = BSM_SERIAL_LOAD_BOOT; // see RULE3
      TWO_WIRE_RUN_CODE: bsm_flow_of = BSM_RUN_WITH_TWO_WIRE_DEBUG; // see RULE5
      FOUR_WIRE_RUN_CODE: bsm_flow_of = BSM_RUN_WITH_FOUR_WIRE_DEBUG; // see RULE6
      BREAK_DETECT_CODE: bsm_flow_of = BSM_BREAK_DETECT_BOOT; // see RULE7
      FACTORY_RESTORE_CODE: bsm_flow_of = BSM_FACTORY_RESTORE_BOOT; // see RULE8
      default: bsm_flow_of = BSM_RUN_WITH_FOUR_WIRE_DEBUG; // see RULE12
    endcase
  endfunction

  assign flow_out = bsm_flow_of(code_in);
  assign four_wire_out = (flow_out != BSM_RUN_WITH_TWO_WIRE_DEBUG); // see RULE5
endmodule // bsm_decode
`default_nettype wire

// file: design/bsm_pkg.sv
// Purpose: Shared constants for boot strap mode selection
// Assumes: Three strap pins, pulled-up reads as one
// Notes: Codes listed as {bit2,bit1,bit0}
package bsm_pkg;
  localparam int unsigned STRAP_W = 3;
  localparam logic [2:0] SERIAL_LOAD_CODE = 3'h4;
  localparam logic [2:0] TWO_WIRE_RUN_CODE = 3'h1;
  localparam logic [2:0] FOUR_WIRE_RUN_CODE = 3'h0;
  localparam logic [2:0] BREAK_DETECT_CODE = 3'h2;
  localparam logic [2:0] FACTORY_RESTORE_CODE = 3'h3;
  // Release delay after reset, in cycles, before strap capture
  localparam int unsigned SETTLE_CYCLES = 4;
  localparam int unsigned SETTLE_W = 3;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = 3'h3;
  localparam logic [SETTLE_W-1:0] SETTLE_ZERO = 3'h0;
  localparam logic [2:0] STRAP_RST = 3'h0;

  typedef enum logic [2:0]
  {
    BSM_SERIAL_LOAD_BOOT = 3'b000,
    BSM_RUN_WITH_TWO_WIRE_DEBUG = 3'b001,
    BSM_RUN_WITH_FOUR_WIRE_DEBUG = 3'b010,
    BSM_BREAK_DETECT_BOOT = 3'b011,
    BSM_FACTORY_RESTORE_BOOT = 3'b100
  } bsm_flow_t;

  typedef enum logic [1:0]
  {
    BSM_ST_SETTLE = 2'b00,
    BSM_ST_DECIDE = 2'b01,
    BSM_ST_DONE = 2'b10
  } bsm_state_t;
endpackage

// file: dv/bsm_board_model.sv
// Purpose: Board strap pulls and serial loader line
// Assumes: Pull-up reads one; straps held through power-up
// Notes: Loader signals break as a steady low
`timescale 1ns/10ps
`default_nettype none
module bsm_board_model
(
  input wire logic [2:0] pull_up_in, // Pull-up fitted per strap bit
  input wire logic break_in, // Loader holds a break
  output logic [2:0] strap_out, // Strap pin levels
  output logic rx_out // Serial receive line
);
  // Pull-downs by default; strap levels follow pull_up_in directly on every bit
  assign strap_out = pull_up_in;
  assign rx_out = ~break_in;
endmodule // bsm_board_model
`default_nettype wire

// file: dv/tb_boot_strap_mode_select.sv
// Purpose: Self-checking bench for boot strap mode selection
// Assumes: Straps and rx steady until done_out, except in t_mid_stall from the clk_en_in low stall onward
// Notes: Every strap code booted with and without break
`timescale 1ns/10ps
`default_nettype none
module tb_boot_strap_mode_select;
  import bsm_pkg::*;
  logic clk_in, rst_n_in, clk_en_in, brk, done, ld, fn, fr, fw, tw, r2, g01;
  logic [2:0] pulls;
  logic [2:0] code;
  wire logic [2:0] strap;
  wire logic rx;
  bsm_flow_t flow;
  int bad_count, n_compared, cyc;
  bsm_board_model board (.pull_up_in(pulls), .break_in(brk), .strap_out(strap), .rx_out(rx));
  bsm_boot_strap_select dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
    .boot_strap_in(strap), .serial_rx_in(rx), .done_out(done), .strap_code_out(code),
    .flow_out(flow), .serial_load_out(ld), .functional_out(fn), .factory_restore_out(fr),
    .four_wire_debug_out(fw), .two_wire_debug_out(tw), .strap2_reusable_out(r2),
    .strap01_general_out(g01));
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      test_done();
    end
  end
  task automatic boot(input logic [2:0] c, input logic b, input int stall);
    int n;
    @(negedge clk_in);
    rst_n_in = 1'b0;
    pulls = c;
    brk = b;
    clk_en_in = (stall == 0);
    repeat (10) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (stall) @(negedge clk_in);
    check(done, 1'b0);
    clk_en_in = 1'b1;
    n = 0;
    while (n < 20 && done !== 1'b1)
    begin
      @(negedge clk_in);
      n++;
    end
    check(done, 1'b1);
    check(n[7:0], 8'(SETTLE_LAST) + 8'h2);
  endtask
  task automatic expect_mode(input logic [2:0] c, input logic b);
    bsm_flow_t f;
    logic l;
    f = (c == 3'h4) ? BSM_SERIAL_LOAD_BOOT : (c == 3'h1) ? BSM_RUN_WITH_TWO_WIRE_DEBUG :
      (c == 3'h2) ? BSM_BREAK_DETECT_BOOT : (c == 3'h3) ? BSM_FACTORY_RESTORE_BOOT :
      BSM_RUN_WITH_FOUR_WIRE_DEBUG;
    l = (c == 3'h4) || (c == 3'h2 && b);
    check(code, c);
    check(flow, f);
    check(ld, l);
    check(fr, c == 3'h3);
    check(fn, !l && c != 3'h3);
    check({fw, tw}, (c == 3'h1) ? 2'b01 : 2'b10);
    check({r2, g01}, 2'b10);
  endtask
  task automatic t_all_codes();
    for (int i = 0; i < 16; i++)
    begin
      boot(i[2:0], i[3], 0);
      expect_mode(i[2:0], i[3]);
    end
  endtask
  task automatic t_late_change();
    boot(3'h3, 1'b0, 0);
    pulls = 3'h4;
    brk = 1'b1;
    repeat (30) @(negedge clk_in);
    expect_mode(3'h3, 1'b0);
    boot(3'h4, 1'b0, 0);
    pulls = 3'h0;
    repeat (50) @(negedge clk_in);
    check(ld, 1'b1);
    boot(pulls, 1'b0, 0);
    expect_mode(3'h0, 1'b0);
  endtask
  task automatic t_mid_stall();
    @(negedge clk_in);
    rst_n_in = 1'b0;
    pulls = 3'h2;
    brk = 1'b0;
    repeat (10) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    clk_en_in = 1'b0;
    brk = 1'b1;
    pulls = 3'h4;
    repeat (8) @(negedge clk_in);
    check(done, 1'b0);
    check(code, 3'h2);
    brk = 1'b0;
    clk_en_in = 1'b1;
    @(negedge clk_in);
    check(done, 1'b1);
    expect_mode(3'h2, 1'b0);
  endtask
  task automatic t_stall();
    boot(3'h2, 1'b1, 25);
    expect_mode(3'h2, 1'b1);
  endtask
  initial
  begin
    rst_n_in = 1'b0;
    clk_en_in = 1'b1;
    pulls = 3'h0;
    brk = 1'b0;
    bad_count = 0;
    n_compared = 0;
    cyc = 0;
    t_all_codes();
    t_late_change();
    t_stall();
    t_mid_stall();
    test_done();
  end
endmodule // tb_boot_strap_mode_select
`default_nettype wire
